// ### logic/tc_top.sv
// 8-bit up/down interval and auto-reload timer with an AXI4-Lite register slave.
// Assumes pins are synchronous inputs except the event and watch pins, which are resynchronised.
module tc_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  // AXI4-Lite write response
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  // AXI4-Lite read data
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Timer pins
  input  wire logic        event_input_pin,
  input  wire logic        updown_select_pin,
  input  wire logic        watch_clk_pin,
  // Interrupt request
  output      logic        timer_irq
);

  tc_src_if src ();

  tc_edge_sync u_sync (
    .clk             (clk),
    .rst_b           (rst_b),
    .event_input_pin (event_input_pin),
    .watch_clk_pin   (watch_clk_pin),
    .src             (src.sync)
  );

  tc_prescaler u_pre (
    .clk   (clk),
    .rst_b (rst_b),
    .src   (src.pre)
  );

  typedef struct packed {
    logic [7:0]        count_value;
    logic [7:0]        reload_value;
    logic [7:0]        timer_mode_reg;
    logic [7:0]        module_clock_stop_1;
    logic              timer_irq_enable;
    logic              timer_irq_flag;
    logic              edge_rise;
    logic              sub_div8;
    tc_pkg::tc_pmode_t pmode;
    logic              irq;
    logic              aw_held;
    logic [31:0]       aw_addr;
    logic              w_held;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } tc_state_t;

  tc_state_t st;
  tc_state_t next_st;

  // Word decode: upper address bits must be zero, low two bits ignored
  function automatic logic hit(input logic [31:0] addr, input logic [15:0] idx);
    return (addr[31:18] == 14'h0000) && (addr[17:2] == idx);
  endfunction : hit

  function automatic logic mapped(input logic [31:0] addr);
    return hit(addr, tc_pkg::IDX_MODE) || hit(addr, tc_pkg::IDX_COUNT) ||
           hit(addr, tc_pkg::IDX_STOP) || hit(addr, tc_pkg::IDX_CTRL);
  endfunction : mapped

  logic       dir_up;
  logic       sub_mode;
  logic       act_mode;
  logic       use_w8;
  logic       tick;
  logic       run;
  logic [7:0] step;
  logic [8:0] sum;
  logic       wrap;
  logic       do_write;
  logic [7:0] ctrl_rd;

  always_comb begin
    next_st  = st;
    dir_up   = 1'b1;
    sum      = 9'h000;
    wrap     = 1'b0;
    do_write = 1'b0;

    // Direction select; pin high counts up
    if (st.timer_mode_reg[tc_pkg::MODE_HW_DIR]) begin
      dir_up = updown_select_pin;
    end else begin
      dir_up = ~st.timer_mode_reg[tc_pkg::MODE_SW_DIR];
    end

    sub_mode = (st.pmode == tc_pkg::TC_SUBACTIVE) || (st.pmode == tc_pkg::TC_SUBSLEEP);
    act_mode = (st.pmode == tc_pkg::TC_ACTIVE) || (st.pmode == tc_pkg::TC_SLEEP);
    // Subclock at watch over eight steps by two on each tick, so the low bit never changes
    use_w8   = sub_mode && st.sub_div8 && (st.timer_mode_reg[2:0] == tc_pkg::SEL_WATCH);
    step     = use_w8 ? 8'h02 : 8'h01;
    tick     = use_w8 ? src.w8_tick : src.tick[st.timer_mode_reg[2:0]];
    run      = st.module_clock_stop_1[tc_pkg::STOP_TIMER] &&
               (act_mode || (sub_mode && (st.timer_mode_reg[2:0] >= tc_pkg::SEL_WATCH)));

    if (run && tick) begin
      if (dir_up) begin
        sum  = {1'b0, st.count_value} + {1'b0, step};
        wrap = sum[8];
      end else begin
        sum  = {1'b0, st.count_value} - {1'b0, step};
        wrap = (st.count_value < step);
      end
      if (wrap && st.timer_mode_reg[tc_pkg::MODE_RELOAD_SEL]) begin
        next_st.count_value = st.reload_value;
      end else begin
        next_st.count_value = sum[7:0];
      end
    end

    // Write channel capture, address and data in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held  = 1'b1;
      next_st.w_data  = s_axi_wdata[7:0];
      next_st.w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    if (st.aw_held && st.w_held && !st.bvalid) begin
      do_write        = st.w_lane0;
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = mapped(st.aw_addr) ? tc_pkg::RESP_OKAY : tc_pkg::RESP_SLVERR;
    end

    if (do_write) begin
      if (hit(st.aw_addr, tc_pkg::IDX_MODE)) begin
        next_st.timer_mode_reg = st.w_data | tc_pkg::MODE_RSVD_MASK;
      end
      if (hit(st.aw_addr, tc_pkg::IDX_COUNT)) begin
        next_st.reload_value = st.w_data;
        next_st.count_value  = st.w_data;
      end
      if (hit(st.aw_addr, tc_pkg::IDX_STOP)) begin
        next_st.module_clock_stop_1 = st.w_data;
      end
      if (hit(st.aw_addr, tc_pkg::IDX_CTRL)) begin
        next_st.timer_irq_enable = st.w_data[tc_pkg::CTRL_IRQ_EN];
        next_st.edge_rise        = st.w_data[tc_pkg::CTRL_EDGE];
        next_st.sub_div8         = st.w_data[tc_pkg::CTRL_SUB_DIV8];
        next_st.pmode            = tc_pkg::tc_pmode_t'(st.w_data[tc_pkg::CTRL_PMODE_LO +: 3]);
        if (st.w_data[tc_pkg::CTRL_IRQ_FLAG]) begin
          next_st.timer_irq_flag = 1'b0;
        end
      end
    end

    // Set after clear so an overflow in the clearing cycle is kept
    if (wrap) begin
      next_st.timer_irq_flag = 1'b1;
    end
    next_st.irq = next_st.timer_irq_flag && next_st.timer_irq_enable;

    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready  = !next_st.w_held && !next_st.bvalid;

    // Read channel
    ctrl_rd = 8'h00;
    ctrl_rd[tc_pkg::CTRL_IRQ_EN]             = st.timer_irq_enable;
    ctrl_rd[tc_pkg::CTRL_IRQ_FLAG]           = st.timer_irq_flag;
    ctrl_rd[tc_pkg::CTRL_EDGE]               = st.edge_rise;
    ctrl_rd[tc_pkg::CTRL_SUB_DIV8]           = st.sub_div8;
    ctrl_rd[tc_pkg::CTRL_PMODE_LO +: 3]      = st.pmode;
    if (s_axi_rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = mapped(s_axi_araddr) ? tc_pkg::RESP_OKAY : tc_pkg::RESP_SLVERR;
      next_st.rdata  = 32'h0000_0000;
      if (hit(s_axi_araddr, tc_pkg::IDX_MODE)) begin
        next_st.rdata[7:0] = st.timer_mode_reg | tc_pkg::MODE_RSVD_MASK;
      end
      if (hit(s_axi_araddr, tc_pkg::IDX_COUNT)) begin
        next_st.rdata[7:0] = st.count_value;
      end
      if (hit(s_axi_araddr, tc_pkg::IDX_STOP)) begin
        next_st.rdata[7:0] = st.module_clock_stop_1;
      end
      if (hit(s_axi_araddr, tc_pkg::IDX_CTRL)) begin
        next_st.rdata[7:0] = ctrl_rd;
      end
    end
    next_st.arready = !next_st.rvalid;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st                     <= '0;
      st.count_value         <= tc_pkg::RST_COUNT;
      st.reload_value        <= tc_pkg::RST_RELOAD;
      st.timer_mode_reg      <= tc_pkg::RST_MODE;
      st.module_clock_stop_1 <= tc_pkg::RST_STOP;
      st.pmode               <= tc_pkg::TC_ACTIVE;
      st.awready             <= 1'b1;
      st.wready              <= 1'b1;
      st.arready             <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign src.edge_rise = st.edge_rise;

  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rresp   = st.rresp;
  assign s_axi_rdata   = st.rdata;
  assign timer_irq     = st.irq;

endmodule : tc_top

// ### common/tc_pkg.sv
// Constants, register map and field layout of the 8-bit up/down reload timer.
// Assumes a 200 MHz system clock and AXI4-Lite access with one 32-bit word per register.
package tc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_MODE  = 16'hFFB4;
  localparam logic [15:0] IDX_COUNT = 16'hFFB5;
  localparam logic [15:0] IDX_STOP  = 16'hFFFA;
  localparam logic [15:0] IDX_CTRL  = 16'hFFB0;

  // Reset values
  localparam logic [7:0] RST_MODE   = 8'h18;
  localparam logic [7:0] RST_COUNT  = 8'h00;
  localparam logic [7:0] RST_RELOAD = 8'h00;
  localparam logic [7:0] RST_STOP   = 8'hFF;

  // Mode register fields
  localparam int MODE_RELOAD_SEL = 7;
  localparam int MODE_HW_DIR     = 6;
  localparam int MODE_SW_DIR     = 5;
  localparam logic [7:0] MODE_RSVD_MASK = 8'h18;

  // Module stop register: timer standby control bit
  localparam int STOP_TIMER = 1;

  // Control register fields
  localparam int CTRL_IRQ_EN   = 0;
  localparam int CTRL_IRQ_FLAG = 1;
  localparam int CTRL_EDGE     = 2;
  localparam int CTRL_SUB_DIV8 = 3;
  localparam int CTRL_PMODE_LO = 4;

  // Clock select codes
  localparam logic [2:0] SEL_WATCH = 3'h6;
  localparam logic [2:0] SEL_EVENT = 3'h7;

  // Prescaler S and W shapes, as log2 of the division
  localparam int PRE_WIDTH = 13;
  localparam int DIV_LOG_0 = 13;
  localparam int DIV_LOG_1 = 11;
  localparam int DIV_LOG_2 = 9;
  localparam int DIV_LOG_3 = 6;
  localparam int DIV_LOG_4 = 4;
  localparam int DIV_LOG_5 = 2;
  localparam logic [2:0] WATCH_DIV4_LAST = 3'h3;
  localparam logic [2:0] WATCH_DIV8_LAST = 3'h7;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    TC_ACTIVE, TC_SLEEP, TC_WATCH, TC_SUBACTIVE, TC_SUBSLEEP, TC_STANDBY
  } tc_pmode_t;

endpackage : tc_pkg

// ### common/tc_src_if.sv
// Counting-clock sources passed between the timer core, synchroniser and prescaler.
// All signals are one-cycle enables or levels in the single clk domain.
interface tc_src_if;
  logic       edge_rise;
  logic       event_edge;
  logic       watch_rise;
  logic [7:0] tick;
  logic       w8_tick;

  modport sync (input edge_rise, output event_edge, output watch_rise);
  modport pre  (input event_edge, input watch_rise, output tick, output w8_tick);
  modport core (output edge_rise, input tick, input w8_tick);
endinterface : tc_src_if

// ### logic/tc_edge_sync.sv
// Two-flop synchronisers and edge detectors for the event pin and the watch clock pin.
// Assumes both pins may change at any time relative to clk.
module tc_edge_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Pins
  input  wire logic event_input_pin,
  input  wire logic watch_clk_pin,
  // Source enables
  tc_src_if.sync    src
);

  typedef struct packed {
    logic ev_s1;
    logic ev_s2;
    logic ev_s3;
    logic wc_s1;
    logic wc_s2;
    logic wc_s3;
    logic event_edge;
    logic watch_rise;
  } tc_sync_t;

  tc_sync_t st;
  tc_sync_t next_st;

  always_comb begin
    next_st            = st;
    next_st.ev_s1      = event_input_pin;
    next_st.ev_s2      = st.ev_s1;
    next_st.ev_s3      = st.ev_s2;
    next_st.wc_s1      = watch_clk_pin;
    next_st.wc_s2      = st.wc_s1;
    next_st.wc_s3      = st.wc_s2;
    // One pulse per qualified edge, never two
    next_st.event_edge = src.edge_rise ? (st.ev_s2 & ~st.ev_s3) : (~st.ev_s2 & st.ev_s3);
    next_st.watch_rise = st.wc_s2 & ~st.wc_s3;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign src.event_edge = st.event_edge;
  assign src.watch_rise = st.watch_rise;

endmodule : tc_edge_sync

// ### logic/tc_prescaler.sv
// Prescaler S (system clock) and prescaler W (synchronised watch clock) enables.
// Assumes watch_rise is already a one-cycle pulse in the clk domain.
module tc_prescaler (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Source enables
  tc_src_if.pre     src
);

  typedef struct packed {
    logic [tc_pkg::PRE_WIDTH-1:0] pre_s;
    logic [2:0]                   pre_w;
    logic [7:0]                   tick;
    logic                         w8_tick;
  } tc_pre_t;

  tc_pre_t st;
  tc_pre_t next_st;

  function automatic logic low_ones(input logic [tc_pkg::PRE_WIDTH-1:0] v, input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < n; i++) begin
      r = r & v[i];
    end
    return r;
  endfunction : low_ones

  always_comb begin
    next_st         = st;
    next_st.pre_s   = st.pre_s + 1'b1;
    next_st.tick[0] = low_ones(st.pre_s, tc_pkg::DIV_LOG_0);
    next_st.tick[1] = low_ones(st.pre_s, tc_pkg::DIV_LOG_1);
    next_st.tick[2] = low_ones(st.pre_s, tc_pkg::DIV_LOG_2);
    next_st.tick[3] = low_ones(st.pre_s, tc_pkg::DIV_LOG_3);
    next_st.tick[4] = low_ones(st.pre_s, tc_pkg::DIV_LOG_4);
    next_st.tick[5] = low_ones(st.pre_s, tc_pkg::DIV_LOG_5);
    next_st.tick[6] = src.watch_rise && (st.pre_w[1:0] == tc_pkg::WATCH_DIV4_LAST[1:0]);
    next_st.tick[7] = src.event_edge;
    next_st.w8_tick = src.watch_rise && (st.pre_w == tc_pkg::WATCH_DIV8_LAST);
    if (src.watch_rise) begin
      next_st.pre_w = st.pre_w + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign src.tick    = st.tick;
  assign src.w8_tick = st.w8_tick;

endmodule : tc_prescaler

// ### verification/tc_pins_model.sv
// Far-side pin model: external event source and free-running watch clock.
// Assumes the bench calls pulse() and that software has set up the pin functions.
module tc_pins_model (
  // Pins toward the timer
  output logic event_input_pin,
  output logic watch_clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle low; software gave the pins their timer function first
  initial begin
    event_input_pin = 1'b0;
    watch_clk_pin   = 1'b0;
  end

  // Watch crystal runs free, unrelated in phase to clk
  always #51.3 watch_clk_pin = ~watch_clk_pin;

  // Each pulse gives one rising and one falling edge
  task automatic pulse(input int n);
    repeat (n) begin
      #40.7 event_input_pin = 1'b1;
      #40.7 event_input_pin = 1'b0;
    end
  endtask : pulse
endmodule : tc_pins_model

// ### verification/tc_top_properties.sv
// Port checks of the timer's register slave and interrupt output.
// Assumes it is bound to tc_top and sees only its ports.
module tc_top_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Interrupt
  input wire logic        timer_irq
);
  localparam logic [31:0] MODE_A = {14'h0, tc_pkg::IDX_MODE, 2'h0};
  logic [31:0] ar_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Address of the read in flight
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ar_q <= 32'h0;
    else if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end

  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  AST_RD_ANSWER: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_WR_ANSWER: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles later");
  AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_READY_BACK: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
    else $error("write channels not ready after response");
  AST_DATA_WIDTH: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_MODE_RSVD: assert property (s_axi_rvalid && ar_q == MODE_A |-> s_axi_rdata[4:3] == 2'h3)
    else $error("mode reserved bits not one");
  AST_UNMAPPED: assert property (s_axi_rvalid && s_axi_rresp == tc_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("unmapped read returned data");
  AST_IRQ_CLEAR: assert property ($fell(timer_irq) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("interrupt fell without a register write");
endmodule : tc_top_properties

bind tc_top tc_top_properties tc_top_properties_i (
  .clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_irq(timer_irq)
);

// ### verification/tc_top_test.sv
// Self-checking bench: AXI4-Lite register tasks and directed timer sequences.
// Assumes the pin model drives the event and watch pins.
module tc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_MODE = {14'h0, tc_pkg::IDX_MODE, 2'h0};
  localparam logic [31:0] A_CNT  = {14'h0, tc_pkg::IDX_COUNT, 2'h0};
  localparam logic [31:0] A_STOP = {14'h0, tc_pkg::IDX_STOP, 2'h0};
  localparam logic [31:0] A_CTRL = {14'h0, tc_pkg::IDX_CTRL, 2'h0};
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, ud = 1'b1;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid, irq, ev, wclk;
  logic [1:0]  bresp, rresp, rs, bs;
  logic [31:0] rdata, r, q;
  int          err_count = 0;
  int          checked = 0;

  always #2.5 clk = ~clk;

  tc_pins_model tc_pins_model_i (.event_input_pin(ev), .watch_clk_pin(wclk));
  tc_top tc_top_i (
    .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_input_pin(ev), .updown_select_pin(ud),
    .watch_clk_pin(wclk), .timer_irq(irq)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Late bready and rready exercise the slave's hold of its answer
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awready === 1'b1) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    repeat (2) @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  // Whole run is about 10k cycles
  initial begin
    #150us;
    err_count++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rd(A_MODE, r);
    chk(r, 32'h18);
    rd(A_CNT, r);
    chk(r[31:1], 32'h0);
    rd(A_STOP, r);
    chk(r, 32'hFF);
    repeat (8300) @(posedge clk);
    rd(A_CNT, r);
    chk(r, 32'h1);
    wr(A_MODE, 8'h00);
    rd(A_MODE, r);
    chk(r, 32'h18);
    chk(bs, tc_pkg::RESP_OKAY);
    chk(rs, tc_pkg::RESP_OKAY);
    // Interval up from FD on clk/4 must wrap and flag
    wr(A_CTRL, 8'h01);
    wr(A_MODE, 8'h05);
    wr(A_CNT, 8'hFD);
    repeat (40) @(posedge clk);
    rd(A_CNT, r);
    chk(r < 32'h10, 32'h1);
    rd(A_CTRL, r);
    chk(r[1], 32'h1);
    chk(irq, 32'h1);
    wr(A_CTRL, 8'h03);
    repeat (3) @(posedge clk);
    chk(irq, 32'h0);
    // Software down count underflows to FF side
    wr(A_MODE, 8'h25);
    wr(A_CNT, 8'h02);
    repeat (40) @(posedge clk);
    rd(A_CNT, r);
    chk(r[31:4], 32'hF);
    rd(A_CTRL, r);
    chk(r[1], 32'h1);
    // Reload FE gives a two-tick period
    wr(A_MODE, 8'h85);
    wr(A_CNT, 8'hFE);
    repeat (40) @(posedge clk);
    rd(A_CNT, r);
    chk(r[31:1], 32'h7F);
    wr(A_STOP, 8'hFD);
    rd(A_STOP, r);
    chk(r, 32'hFD);
    rd(A_CNT, q);
    repeat (40) @(posedge clk);
    rd(A_CNT, r);
    chk(r, q);
    wr(A_STOP, 8'hFF);
    // Lane 0 strobe low: the write must be ignored
    wstrb <= 4'h0;
    wr(A_STOP, 8'h00);
    wstrb <= 4'hF;
    rd(A_STOP, r);
    chk(r, 32'hFF);
    // Subactive halts clk/4 but runs on the watch clock
    wr(A_CTRL, 8'h30);
    rd(A_CNT, q);
    repeat (40) @(posedge clk);
    rd(A_CNT, r);
    chk(r, q);
    wr(A_MODE, 8'h06);
    wr(A_CNT, 8'h00);
    repeat (400) @(posedge clk);
    rd(A_CNT, r);
    chk(r >= 32'h3 && r <= 32'h6, 32'h1);
    // Subclock at watch over eight: steps of two, low bit never moves
    wr(A_CTRL, 8'h38);
    wr(A_CNT, 8'h00);
    repeat (400) @(posedge clk);
    rd(A_CNT, r);
    chk(r == 32'h4 || r == 32'h6, 32'h1);
    // Watch mode halts even on the watch clock
    wr(A_CTRL, 8'h20);
    rd(A_CNT, q);
    repeat (200) @(posedge clk);
    rd(A_CNT, r);
    chk(r, q);
    // Rising event edges, then pin-controlled direction
    wr(A_CTRL, 8'h04);
    wr(A_MODE, 8'h07);
    wr(A_CNT, 8'h10);
    tc_pins_model_i.pulse(5);
    repeat (10) @(posedge clk);
    rd(A_CNT, r);
    chk(r, 32'h15);
    ud <= 1'b0;
    wr(A_MODE, 8'h47);
    tc_pins_model_i.pulse(3);
    repeat (10) @(posedge clk);
    rd(A_CNT, r);
    chk(r, 32'h12);
    ud <= 1'b1;
    tc_pins_model_i.pulse(2);
    repeat (10) @(posedge clk);
    rd(A_CNT, r);
    chk(r, 32'h14);
    // Falling-edge selection counts one per pulse as well
    wr(A_CTRL, 8'h00);
    tc_pins_model_i.pulse(1);
    repeat (10) @(posedge clk);
    rd(A_CNT, r);
    chk(r, 32'h15);
    rd(32'h0, r);
    chk(rs, tc_pkg::RESP_SLVERR);
    chk(r, 32'h0);
    wr(32'h4, 8'h00);
    chk(bs, tc_pkg::RESP_SLVERR);
    end_sim();
  end
endmodule : tc_top_test
